// ### fbds_pkg.sv
// Shared constants for the dual-slave field bus I/O logic
package fbds_pkg;
  // APB register byte offsets
  localparam logic [7:0] FBDS_OFF_CTRL   = 8'h00; // Variant, supply, faults
  localparam logic [7:0] FBDS_OFF_ADDR   = 8'h04; // Slave addresses
  localparam logic [7:0] FBDS_OFF_LINK   = 8'h08; // Per-slave link state
  localparam logic [7:0] FBDS_OFF_BUSIN  = 8'h0C; // Bus input bits
  localparam logic [7:0] FBDS_OFF_BUSOUT = 8'h10; // Bus output bits, read
  localparam logic [7:0] FBDS_OFF_STAT   = 8'h14; // Commissioning state and visibility, read
  // Field positions in CTRL
  localparam int FBDS_CTRL_DUAL   = 0; // Dual slave connector variant
  localparam int FBDS_CTRL_SUPPLY = 1; // Bus supply voltage present
  localparam int FBDS_CTRL_PERR   = 2; // Peripheral error
  localparam int FBDS_CTRL_UPDATE = 3; // Controller update mode
  localparam int FBDS_CTRL_COMLOS = 4; // Communication lost
  // Field positions in LINK, per slave s at 4*(s-1)
  localparam int FBDS_LINK_EXCH   = 0; // Data exchange active
  // Slave address width and limits
  localparam int FBDS_AW = 6;
  localparam logic [5:0] FBDS_MAX_STD = 6'h1F; // 31 standard slaves
  localparam logic [6:0] FBDS_MAX_EXT = 7'h3E; // 62 extended slaves
  // Reset values
  localparam logic [4:0] FBDS_CTRL_RST = 5'h01;
  // Timing
  localparam int FBDS_CLK_HZ     = 50_000_000;
  localparam int FBDS_FLASH_HZ   = 2;
  localparam int FBDS_HALF_CYC   = FBDS_CLK_HZ / (2 * FBDS_FLASH_HZ);
  localparam int FBDS_VANISH_S   = 10;
  localparam int FBDS_VANISH_CYC = FBDS_CLK_HZ * FBDS_VANISH_S;
  // Indicator colour codes {red, green}
  localparam logic [1:0] FBDS_LED_OFF = 2'h0;
  localparam logic [1:0] FBDS_LED_GRN = 2'h1;
  localparam logic [1:0] FBDS_LED_RED = 2'h2;
  // Commissioning states of the slave pair
  typedef enum logic [2:0] {
    FBDS_S1_NEW  = 3'b001, // Slave 1 at address 0
    FBDS_S2_VIS  = 3'b010, // Slave 1 addressed, slave 2 visible
    FBDS_S1_GONE = 3'b100  // Slave 1 hidden after re-zeroing
  } fbds_comm_e;
endpackage

// ### fbds_io_logic.sv
// Application logic of a two-slave field bus node in a motor drive
//
// What this block does
// - Address fields 6 bits wide, every value accepted
// - One status indicator per slave
// - Indicator dark without bus supply
// - Steady green in active operation
// - Steady red when no data exchange
// - Red flashing 2 Hz while slave not visible
// - Red/green alternate on error or update
// - Bits 0/1 enable right/left, bit 2 jog
// - Bits 1:0 decode to motor rotation
// - Fault acknowledge on bit 3 rising edge
// - Enable edges never acknowledge faults
// - Output bits: drive state code, inputs 1, 4
// - Output bits 1:0 encode drive state
// - Dual variant: bit 4 remote, bit 5 torque
// - Dual variant: bit 4 releases brake
// - Bus bits act parallel to inputs
// - Communication loss drops all bus command bits
// - Slave 1 at 0: only slave 1 visible
// - Slave 1 addressed: slave 2 appears
// - Slave 2 addressed: its indicator green
// - Single variant exposes one slave only
// - Re-zeroed slave 1 vanishes after 10 s
//
// Implementation choices: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module fbds_io_logic
  import fbds_pkg::*;
#(
  parameter int VANISH_CYC = FBDS_VANISH_CYC // Hide delay, shortenable
) (
  input  wire logic        clk_sys,      // System clock, 50 MHz
  input  wire logic        rst_n,        // Async reset, active low
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB enable
  input  wire logic        pwrite,       // APB direction
  input  wire logic [7:0]  paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  input  wire logic        digIn1,       // Local digital input 1 pin
  input  wire logic        digIn4,       // Local digital input 4 pin
  input  wire logic        localEnRight, // Local enable right pin
  input  wire logic        localEnLeft,  // Local enable left pin
  input  wire logic        driveFault,   // Drive fault pending
  input  wire logic        driveWarn,    // Drive warning
  input  wire logic        driveInhibit, // Switch-on inhibit
  input  wire logic        remoteSel,    // Local/remote selector remote
  input  wire logic        torqueOffN,   // Safe torque off inactive
  output logic             runRight,     // Right rotating field
  output logic             runLeft,      // Left rotating field
  output logic             jogSel2,      // Jog frequency 2 chosen
  output logic             faultAck,     // Fault acknowledge pulse
  output logic             brakeRelease, // Manual brake release
  output logic             slave1Vis,    // Slave 1 visible on bus
  output logic             slave2Vis,    // Slave 2 visible on bus
  output logic      [1:0]  led1,         // Slave 1 LED {red, green}
  output logic      [1:0]  led2          // Slave 2 LED {red, green}
);

  // Registers written by software
  logic [4:0]        ctrl_q;   // Variant, supply, error flags
  logic [FBDS_AW-1:0] addr1_q; // Slave 1 address
  logic [FBDS_AW-1:0] addr2_q; // Slave 2 address
  logic [7:0]        link_q;   // Per-slave link flags
  logic [4:0]        busIn_q;  // Received bus input bits
  // Pin synchronisers
  logic [4:0] pinMeta_q;       // First stage, read only by second
  logic [4:0] pinSync_q;       // Second stage
  // Edge detection and timing
  logic        ackPrev_q;      // Bit 3 last value
  logic        ackPulse_q;     // Registered acknowledge
  logic [23:0] halfCnt_q;      // Flash half-period prescaler
  logic        phase_q;        // Flash phase
  logic [31:0] vanCnt_q;       // Hide delay counter
  fbds_comm_e  comm_q;         // Commissioning state
  fbds_comm_e  comm_d;
  logic        addr1Zero_q;    // Slave 1 address was zero

  // Address decode on the APB bus
  wire        apbAcc   = psel & penable;
  wire        wrStb    = apbAcc & pwrite;
  wire        hitCtrl  = (paddr == FBDS_OFF_CTRL);
  wire        hitAddr  = (paddr == FBDS_OFF_ADDR);
  wire        hitLink  = (paddr == FBDS_OFF_LINK);
  wire        hitBusIn = (paddr == FBDS_OFF_BUSIN);
  wire        hitOut   = (paddr == FBDS_OFF_BUSOUT);
  wire        hitStat  = (paddr == FBDS_OFF_STAT);
  wire        mapped   = hitCtrl | hitAddr | hitLink | hitBusIn
                         | hitOut | hitStat;

  // Convenient flags
  wire dual    = ctrl_q[FBDS_CTRL_DUAL];
  wire supply  = ctrl_q[FBDS_CTRL_SUPPLY];
  wire altErr  = ctrl_q[FBDS_CTRL_PERR] | ctrl_q[FBDS_CTRL_UPDATE];
  wire comLost = ctrl_q[FBDS_CTRL_COMLOS];
  wire exch1   = link_q[FBDS_LINK_EXCH];
  wire exch2   = link_q[4 + FBDS_LINK_EXCH];
  wire a1Zero  = (addr1_q == '0);
  wire a2Zero  = (addr2_q == '0);

  // Address legality: only bits 4:0 compared with 31, so every 6-bit value passes
  function automatic logic addrOk(input logic [FBDS_AW-1:0] a);
    addrOk = (a[4:0] <= FBDS_MAX_STD[4:0]);
  endfunction
  wire addrWrOk = addrOk(pwdata[FBDS_AW-1:0])
                  & addrOk(pwdata[8+FBDS_AW-1:8]);

  // APB answers with zero wait, error on unmapped address
  assign pready  = 1'b1;
  assign pslverr = apbAcc & (~mapped | (wrStb & hitAddr & ~addrWrOk));

  // Read multiplexer
  wire [5:0] busOut;
  always_comb begin
    prdata = 32'h0;
    if (hitCtrl) begin
      prdata[4:0] = ctrl_q;
    end else if (hitAddr) begin
      prdata[FBDS_AW-1:0]    = addr1_q;
      prdata[8+FBDS_AW-1:8] = addr2_q;
    end else if (hitLink) begin
      prdata[7:0] = link_q;
    end else if (hitBusIn) begin
      prdata[4:0] = busIn_q;
    end else if (hitOut) begin
      prdata[5:0] = busOut;
    end else if (hitStat) begin
      prdata[2:0] = comm_q;
      prdata[4:3] = {slave2Vis, slave1Vis};
    end
  end

  // Register writes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= FBDS_CTRL_RST;
      addr1_q <= '0;
      addr2_q <= '0;
      link_q  <= 8'h00;
      busIn_q <= 5'h00;
    end else if (wrStb) begin
      if (hitCtrl) ctrl_q <= pwdata[4:0];
      if (hitAddr && addrWrOk) begin
        addr1_q <= pwdata[FBDS_AW-1:0];
        addr2_q <= pwdata[8+FBDS_AW-1:8];
      end
      if (hitLink) link_q <= pwdata[7:0];
      if (hitBusIn) busIn_q <= pwdata[4:0];
    end
  end

  // Two-stage synchroniser for the local pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pinMeta_q <= 5'h00;
      pinSync_q <= 5'h00;
    end else begin
      pinMeta_q <= {localEnLeft, localEnRight, digIn4, digIn1, 1'b0};
      pinSync_q <= pinMeta_q;
    end
  end

  // Bus command bits, dropped while communication is lost
  wire [4:0] cmd = comLost ? 5'h00 : busIn_q;
  wire busR = cmd[0] | pinSync_q[3];
  wire busL = cmd[1] | pinSync_q[4];

  // Rotation decode: both or neither means off
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      runRight <= 1'b0;
      runLeft  <= 1'b0;
      jogSel2  <= 1'b0;
      brakeRelease <= 1'b0;
    end else begin
      runRight <= busR & ~busL;
      runLeft  <= busL & ~busR;
      jogSel2  <= cmd[2];
      brakeRelease <= dual & cmd[4];
    end
  end

  // Fault acknowledge: only bit 3 rising, never enable edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ackPrev_q  <= 1'b0;
      ackPulse_q <= 1'b0;
    end else begin
      ackPrev_q  <= cmd[3];
      ackPulse_q <= cmd[3] & ~ackPrev_q;
    end
  end
  assign faultAck = ackPulse_q;

  // Bus output bits: state code, inputs, variant extras
  wire [1:0] stCode = driveFault   ? 2'h0 :
                      driveWarn    ? 2'h1 :
                      driveInhibit ? 2'h2 : 2'h3;
  assign busOut = {dual & torqueOffN, dual & remoteSel,
                   pinSync_q[2], pinSync_q[1], stCode};

  // Flash prescaler: equal halves at 2 Hz
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      halfCnt_q <= 24'h0;
      phase_q   <= 1'b0;
    end else if (halfCnt_q == 24'(FBDS_HALF_CYC - 1)) begin
      halfCnt_q <= 24'h0;
      phase_q   <= ~phase_q;
    end else begin
      halfCnt_q <= halfCnt_q + 24'h1;
    end
  end

  // Commissioning sequence of the two slaves
  always_comb begin
    comm_d = comm_q;
    case (comm_q)
      FBDS_S1_NEW:  if (dual && !a1Zero) comm_d = FBDS_S2_VIS;
      FBDS_S2_VIS:  if (a1Zero && vanCnt_q >= 32'(VANISH_CYC))
                      comm_d = FBDS_S1_GONE;
      FBDS_S1_GONE: if (a2Zero) comm_d = FBDS_S1_NEW;
      default:      comm_d = FBDS_S1_NEW;
    endcase
  end

  // State and hide-delay counter
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      comm_q      <= FBDS_S1_NEW;
      vanCnt_q    <= 32'h0;
      addr1Zero_q <= 1'b1;
    end else begin
      comm_q      <= comm_d;
      addr1Zero_q <= a1Zero;
      if (comm_q == FBDS_S2_VIS && a1Zero)
        vanCnt_q <= vanCnt_q + 32'h1;
      else
        vanCnt_q <= 32'h0;
    end
  end

  // Visibility: single variant exposes slave 1 only
  assign slave1Vis = (comm_q != FBDS_S1_GONE);
  assign slave2Vis = dual & (comm_q != FBDS_S1_NEW);

  // Indicator colour per slave
  function automatic logic [1:0] ledMix(input logic vis,
                                        input logic exch,
                                        input logic ph);
    if (!supply)      ledMix = FBDS_LED_OFF;
    else if (altErr)  ledMix = ph ? FBDS_LED_RED : FBDS_LED_GRN;
    else if (!vis)    ledMix = ph ? FBDS_LED_RED : FBDS_LED_OFF;
    else if (exch)    ledMix = FBDS_LED_GRN;
    else              ledMix = FBDS_LED_RED;
  endfunction

  // Registered LED outputs, one per slave
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      led1 <= FBDS_LED_OFF;
      led2 <= FBDS_LED_OFF;
    end else begin
      led1 <= ledMix(slave1Vis, exch1 & !a1Zero, phase_q);
      led2 <= dual ? ledMix(slave2Vis, exch2 & !a2Zero, phase_q)
                   : FBDS_LED_OFF;
    end
  end

  // Checks on the drive command path
  chk_rot_exclusive: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !(runRight && runLeft))
    else $error("both directions on");
  chk_both_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (busR && busL) |=> (!runRight && !runLeft))
    else $error("both enables must stop motor");
  chk_local_right: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (pinSync_q[3] && !pinSync_q[4] && !cmd[1]) |=> runRight)
    else $error("local enable ignored");
  chk_jog_follow: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !comLost |=> (jogSel2 == $past(busIn_q[2])))
    else $error("jog select not followed");
  chk_ack_edge: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    faultAck |-> ($past(cmd[3]) && !$past(ackPrev_q)))
    else $error("ack without edge");
  chk_ack_once: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    faultAck |=> !faultAck)
    else $error("ack longer than one cycle");
  chk_comlost_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (comLost && !pinSync_q[3] && !pinSync_q[4]) |=> !runRight && !runLeft)
    else $error("drive runs after loss");
  chk_brake_var: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    brakeRelease |-> $past(dual))
    else $error("brake on single");
  chk_brake_follow: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (dual && !comLost) |=> (brakeRelease == $past(busIn_q[4])))
    else $error("brake bit not followed");

  // Checks on the reported drive state
  chk_out_bits: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    driveFault |-> busOut[1:0] == 2'h0)
    else $error("fault code");
  chk_out_ready: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!driveFault && !driveWarn && !driveInhibit) |-> busOut[1:0] == 2'h3)
    else $error("ready code");
  chk_out_warn: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!driveFault && driveWarn) |-> busOut[1:0] == 2'h1)
    else $error("warning code");
  chk_out_single: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !dual |-> busOut[5:4] == 2'h0)
    else $error("extra bits on single variant");

  // Checks on the commissioning sequence
  chk_s2_hidden: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (comm_q == FBDS_S1_NEW) |-> !slave2Vis)
    else $error("slave 2 visible early");
  chk_s2_after: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (comm_q == FBDS_S1_NEW && dual && !a1Zero) |=> slave2Vis)
    else $error("slave 2 not shown");
  chk_hide_hold: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (comm_q == FBDS_S2_VIS && !a1Zero) |=> comm_q == FBDS_S2_VIS)
    else $error("slave 1 hidden while addressed");
  chk_return_s1: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (comm_q == FBDS_S1_GONE && a2Zero) |=> slave1Vis)
    else $error("slave 1 not restored");

  // Checks on the indicators
  chk_led_dark: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (!supply ##1 !supply) |-> led1 == FBDS_LED_OFF)
    else $error("led lit without supply");
  chk_led2_dark: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !supply |=> led2 == FBDS_LED_OFF)
    else $error("led2 lit without supply");
  chk_led2_single: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !dual |=> led2 == FBDS_LED_OFF)
    else $error("led2 lit on single variant");
  chk_led_green: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (supply && !altErr && slave1Vis && exch1 && !a1Zero)
      |=> led1 == FBDS_LED_GRN)
    else $error("led1 not green");
  chk_led2_green: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (dual && supply && !altErr && slave2Vis && exch2 && !a2Zero)
      |=> led2 == FBDS_LED_GRN)
    else $error("led2 not green");
  chk_led_red: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (supply && !altErr && slave1Vis && (!exch1 || a1Zero))
      |=> led1 == FBDS_LED_RED)
    else $error("led1 not red");
  chk_led_flash: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (dual && supply && !altErr && !slave2Vis)
      |=> led2 == ($past(phase_q) ? FBDS_LED_RED : FBDS_LED_OFF))
    else $error("hidden slave not flashing red");
  chk_led_alt: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (supply && altErr)
      |=> led1 == ($past(phase_q) ? FBDS_LED_RED : FBDS_LED_GRN))
    else $error("led1 not alternating");
  chk_flash_phase: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (halfCnt_q == 24'h0 && $past(halfCnt_q) != 24'h0)
      |-> phase_q != $past(phase_q))
    else $error("phase not toggled");

endmodule

// ### fbds_master_model.sv
// Behavioural model of the field bus master seen by the node
`timescale 1ns/1ps
module fbds_master_model (
  input  wire logic       commLost,  // Link broken towards the node
  input  wire logic [4:0] cmdBits,   // Control bits the program wants
  input  wire logic [5:0] slaveAddr, // Address about to be handed out
  input  wire logic [5:0] otherAddr, // Address held by the other slave
  output logic      [4:0] ctrlBits,  // Control bits put on the bus
  output logic            addrOk     // Address may be assigned
);
  // Zero every control bit once the link fails, so no restart follows
  assign ctrlBits = commLost ? 5'h00 : cmdBits;
  // Never hand one nonzero address to both slaves
  assign addrOk = (slaveAddr == 6'h00) || (slaveAddr != otherAddr);
endmodule

// ### test_fbds_io_logic.sv
// Self-checking bench for the dual-slave field bus I/O logic
`timescale 1ns/1ps
module test_fbds_io_logic;
  import fbds_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, addrOk;
  logic digIn1 = 0, digIn4 = 0, localEnRight = 0, localEnLeft = 0;
  logic driveFault = 0, driveWarn = 0, driveInhibit = 0;
  logic remoteSel = 0, torqueOffN = 0, commLost = 0;
  logic runRight, runLeft, jogSel2, faultAck, brakeRelease;
  logic slave1Vis, slave2Vis;
  logic [1:0] led1, led2;
  logic [4:0] cmdBits = 5'h00, ctrlBits; // Master intent and bus bits
  int failures = 0, cmpCount = 0, ackCnt = 0, cyc = 0;
  // System clock, 20 ns period
  initial begin
    forever #10 clk_sys = ~clk_sys;
  end
  fbds_io_logic #(.VANISH_CYC(20)) dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digIn1(digIn1),
    .digIn4(digIn4), .localEnRight(localEnRight),
    .localEnLeft(localEnLeft), .driveFault(driveFault),
    .driveWarn(driveWarn), .driveInhibit(driveInhibit),
    .remoteSel(remoteSel), .torqueOffN(torqueOffN),
    .runRight(runRight), .runLeft(runLeft), .jogSel2(jogSel2),
    .faultAck(faultAck), .brakeRelease(brakeRelease),
    .slave1Vis(slave1Vis), .slave2Vis(slave2Vis),
    .led1(led1), .led2(led2));
  fbds_master_model master_u (
    .commLost(commLost), .cmdBits(cmdBits), .slaveAddr(6'h07),
    .otherAddr(6'h05), .ctrlBits(ctrlBits), .addrOk(addrOk));
  // Count acknowledge pulses and cut a hang short
  always @(posedge clk_sys) begin
    if (faultAck === 1'b1) ackCnt++;
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end
  // Compare one value with its expectation
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer: setup, access, wait for ready
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Write a register and let its effects land
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    repeat (4) @(posedge clk_sys);
  endtask
  // Print counts and verdict, then stop
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    apb(1'b0, FBDS_OFF_CTRL, 32'h0);
    chk(rd, 32'h1);
    chk(slave1Vis, 1'b1);
    chk(slave2Vis, 1'b0);
    chk(led1, FBDS_LED_OFF);
    wr(FBDS_OFF_CTRL, 32'h03);
    chk(led1, FBDS_LED_RED);
    chk(led2[0], 1'b0);
    // All jog and direction codes
    for (int i = 0; i < 8; i++) begin
      wr(FBDS_OFF_BUSIN, i);
      chk(runRight, i[1:0] == 2'h1);
      chk(runLeft, i[1:0] == 2'h2);
      chk(jogSel2, i[2]);
    end
    wr(FBDS_OFF_BUSIN, 32'h0);
    localEnRight <= 1'b1;
    repeat (5) @(posedge clk_sys);
    chk(runRight, 1'b1);
    localEnRight <= 1'b0;
    wr(FBDS_OFF_BUSIN, 32'h10);
    chk(brakeRelease, 1'b1);
    wr(FBDS_OFF_BUSIN, 32'h0);
    ackCnt = 0;
    wr(FBDS_OFF_BUSIN, 32'h08);
    chk(ackCnt, 1);
    wr(FBDS_OFF_BUSIN, 32'h09);
    wr(FBDS_OFF_BUSIN, 32'h08);
    chk(ackCnt, 1);
    wr(FBDS_OFF_BUSIN, 32'h00);
    chk(ackCnt, 1);
    wr(FBDS_OFF_BUSIN, 32'h01);
    wr(FBDS_OFF_CTRL, 32'h13);
    chk(runRight, 1'b0);
    commLost <= 1'b1;
    cmdBits <= 5'h01;
    @(posedge clk_sys);
    wr(FBDS_OFF_BUSIN, {27'h0, ctrlBits});
    wr(FBDS_OFF_CTRL, 32'h03);
    chk(runRight, 1'b0);
    // Drive state encoding and reported inputs
    for (int i = 0; i < 4; i++) begin
      driveFault <= (i == 0);
      driveWarn <= (i == 1);
      driveInhibit <= (i == 2);
      digIn1 <= i[0];
      digIn4 <= i[1];
      remoteSel <= i[0];
      torqueOffN <= i[1];
      repeat (5) @(posedge clk_sys);
      apb(1'b0, FBDS_OFF_BUSOUT, 32'h0);
      chk(rd[1:0], i[1:0]);
      chk(rd[3:2], i[1:0]);
      chk(rd[5:4], i[1:0]);
    end
    // Commissioning of the slave pair
    wr(FBDS_OFF_ADDR, 32'h005);
    chk(slave2Vis, 1'b1);
    chk(led1, FBDS_LED_RED);
    wr(FBDS_OFF_LINK, 32'h11);
    chk(led1, FBDS_LED_GRN);
    chk(led2, FBDS_LED_RED);
    chk(addrOk, 1'b1);
    wr(FBDS_OFF_ADDR, 32'h705);
    chk(led2, FBDS_LED_GRN);
    wr(FBDS_OFF_ADDR, 32'h700);
    chk(slave1Vis, 1'b1);
    repeat (30) @(posedge clk_sys);
    chk(slave1Vis, 1'b0);
    chk(led1, FBDS_LED_OFF);
    wr(FBDS_OFF_ADDR, 32'h000);
    chk(slave1Vis, 1'b1);
    chk(slave2Vis, 1'b0);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    wr(FBDS_OFF_CTRL, 32'h07);
    chk(led1, FBDS_LED_GRN);
    wr(FBDS_OFF_CTRL, 32'h02);
    chk(slave2Vis, 1'b0);
    chk(led2, FBDS_LED_OFF);
    wr(FBDS_OFF_BUSIN, 32'h10);
    chk(brakeRelease, 1'b0);
    wr(FBDS_OFF_CTRL, 32'h01);
    chk(led1, FBDS_LED_OFF);
    close_out();
  end
endmodule
